//--- hdl/vel_mode_pkg.sv
/*
 Constants shared by the profile velocity block: register map, field
 positions, reset values, run styles and timing counts.
 Assumes a 100 MHz system clock.
*/
package vel_mode_pkg;
	// Clock and derived timing
	localparam int CLK_PERIOD_NS    = 10;
	localparam int INIT_TIME_NS     = 2000;
	localparam int INIT_CYCLES      = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RAMP_TICK_NS     = 1000;
	localparam int RAMP_TICK_CYCLES = RAMP_TICK_NS / CLK_PERIOD_NS;
	localparam int OVERLOAD_TIME_NS = 20000;
	localparam int OVERLOAD_CYCLES  = (OVERLOAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int INIT_CNT_W       = 8;
	localparam int TICK_CNT_W       = 8;
	localparam int OVL_CNT_W        = 16;

	// Register byte addresses
	localparam logic [15:0] ADDR_CMD        = 16'h6040;
	localparam logic [15:0] ADDR_STATE      = 16'h6044;
	localparam logic [15:0] ADDR_TARGET     = 16'h6048;
	localparam logic [15:0] ADDR_START      = 16'h604c;
	localparam logic [15:0] ADDR_ACCEL      = 16'h6050;
	localparam logic [15:0] ADDR_DEV_LIMIT  = 16'h6054;
	localparam logic [15:0] ADDR_SPEED      = 16'h6058;
	localparam logic [15:0] ADDR_LIMIT_CTRL = 16'h605c;
	localparam logic [15:0] ADDR_ALARM      = 16'h6060;

	// Reset values
	localparam logic [15:0] CMD_RST       = 16'h0000;
	localparam logic [31:0] TARGET_RST    = 32'h0000_0000;
	localparam logic [31:0] START_RST     = 32'h0000_1388;
	localparam logic [31:0] ACCEL_RST     = 32'h0000_0001;
	localparam logic [31:0] DEV_LIMIT_RST = 32'h0000_03e8;

	// Command word fields
	localparam int CMD_HALT_BIT  = 8;
	localparam int CMD_FRST_BIT  = 7;
	localparam int CMD_STYLE_LSB = 12;

	// Status word fields
	localparam int ST_TORQUE_BIT  = 15;
	localparam int ST_ZERO_BIT    = 12;
	localparam int ST_LIMIT_BIT   = 11;
	localparam int ST_REACHED_BIT = 10;
	localparam int ST_INIT_BIT    = 9;
	localparam int ST_WARN_BIT    = 7;
	localparam int DRV_OP_EN_BIT  = 2;

	// Position catch-up gain as a right shift of the deviation
	localparam int DEV_GAIN_SHIFT = 2;

	// Continuous run styles
	typedef enum logic [1:0] {
		STYLE_POSITION = 2'b00,
		STYLE_SPEED    = 2'b01,
		STYLE_PUSH     = 2'b10,
		STYLE_TORQUE   = 2'b11
	} run_style_t;
endpackage : vel_mode_pkg

//--- hdl/speed_ramp.sv
/*
 Speed ramp generator: starts at the starting speed, steps toward the
 goal once per tick, or jumps straight to it.
 Assumes tick_i is a one-cycle enable on the same clock.
*/
`timescale 1ns/10ps
module speed_ramp #(
	parameter int W = 32
) (
	input  wire logic                clk_i,
	input  wire logic                rstn_i,
	input  wire logic                tick_i,
	input  wire logic                jump_i,
	input  wire logic signed [W-1:0] target_i,
	input  wire logic        [W-1:0] start_i,
	input  wire logic        [W-1:0] step_i,
	output logic signed      [W-1:0] speed_o
);
	typedef struct packed {
		logic signed [W-1:0] speed;
	} ramp_t;

	ramp_t s;
	ramp_t next_s;
	logic signed [W:0] goal;
	logic signed [W:0] cur;
	logic signed [W:0] up;
	logic signed [W:0] dn;
	logic signed [W:0] st_s;
	logic        [W-1:0] tgt_mag;
	logic        [W-1:0] spd_mag;

	// Next speed: reverse through zero, snap below start, step or jump
	always_comb begin
		next_s  = s;
		cur     = {s.speed[W-1], s.speed};
		tgt_mag = target_i[W-1] ? W'(-target_i) : target_i;
		spd_mag = s.speed[W-1] ? W'(-s.speed) : s.speed;
		goal    = (s.speed != '0 && target_i != '0 && s.speed[W-1] != target_i[W-1])
			? '0 : {target_i[W-1], target_i};
		up      = cur + $signed({1'b0, step_i});
		dn      = cur - $signed({1'b0, step_i});
		st_s    = target_i[W-1] ? -$signed({1'b0, start_i}) : $signed({1'b0, start_i});
		if (jump_i) begin
			next_s.speed = target_i;
		end else if (tick_i) begin
			if (s.speed == '0 && target_i != '0 && start_i != '0) begin
				next_s.speed = (start_i >= tgt_mag) ? target_i : W'(st_s);
			end else if (goal == '0 && s.speed != '0 && spd_mag <= start_i) begin
				next_s.speed = '0;
			end else if (cur < goal) begin
				next_s.speed = (up > goal) ? W'(goal) : W'(up);
			end else if (cur > goal) begin
				next_s.speed = (dn < goal) ? W'(goal) : W'(dn);
			end
		end
	end

	// State register
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign speed_o = s.speed;
endmodule : speed_ramp

//--- hdl/vel_mode_ctrl.sv
/*
 Profile velocity mode of one axis: command and status words on APB,
 run-style decode, speed ramp, alarms and status flags.
 Assumes limit and torque pins are asynchronous; deviation, warning
 and drive state come from logic on the same clock.
*/
`timescale 1ns/10ps
module vel_mode_ctrl #(
	parameter int OVL_CYCLES = vel_mode_pkg::OVERLOAD_CYCLES
) (
	input  wire logic        CLK_SYS_I,
	input  wire logic        RSTN_I,
	input  wire logic        PSEL_I,
	input  wire logic        PENABLE_I,
	input  wire logic        PWRITE_I,
	input  wire logic [15:0] PADDR_I,
	input  wire logic [31:0] PWDATA_I,
	output logic      [31:0] PRDATA_O,
	output logic             PREADY_O,
	output logic             PSLVERR_O,
	input  wire logic        FORWARD_END_SENSOR_I,
	input  wire logic        REVERSE_END_SENSOR_I,
	input  wire logic        FORWARD_MOTION_INHIBIT_I,
	input  wire logic        REVERSE_MOTION_INHIBIT_I,
	input  wire logic        TORQUE_CEILING_HIT_I,
	input  wire logic [31:0] DEVIATION_I,
	input  wire logic        WARNING_I,
	input  wire logic [6:0]  DRIVE_STATE_I,
	output logic      [31:0] MOTOR_SPEED_O,
	output logic      [15:0] DRIVE_STATE_WORD_O,
	output logic             ALARM_OVERLOAD_O,
	output logic             ALARM_DEVIATION_O,
	output logic             PUSH_HOLD_O
);
	localparam int NPIN = 5;
	localparam int PIN_TORQUE = 4;

	typedef struct packed {
		logic [NPIN-1:0]                       sync1;
		logic [NPIN-1:0]                       sync2;
		logic [15:0]                           cmd;
		logic signed [31:0]                    target;
		logic [31:0]                           start;
		logic [31:0]                           accel;
		logic [31:0]                           dev_limit;
		logic                                  sw_limit;
		logic                                  ovl_alarm;
		logic                                  dev_alarm;
		logic [vel_mode_pkg::OVL_CNT_W-1:0]    ovl_cnt;
		logic [vel_mode_pkg::TICK_CNT_W-1:0]   tick_cnt;
		logic                                  tick;
		logic [vel_mode_pkg::INIT_CNT_W-1:0]   init_cnt;
		logic                                  init_done;
		logic                                  frst_d;
		logic signed [31:0]                    motor_speed;
		logic [15:0]                           status;
		logic                                  push_hold;
		logic                                  pready;
		logic                                  pslverr;
		logic [31:0]                           prdata;
	} ctrl_t;

	ctrl_t                    s;
	ctrl_t                    next_s;
	vel_mode_pkg::run_style_t style;
	logic [NPIN-1:0]          pins;
	logic                     halt;
	logic                     limit_act;
	logic                     stop_req;
	logic signed [31:0]       target_eff;
	logic signed [31:0]       ramp_speed;
	logic signed [31:0]       corr;
	logic [31:0]              dev_mag;
	logic [31:0]              rd_data;
	logic                     rd_hit;
	logic                     wr_en;
	logic                     frst_edge;

	assign pins = {TORQUE_CEILING_HIT_I, REVERSE_MOTION_INHIBIT_I,
		FORWARD_MOTION_INHIBIT_I, REVERSE_END_SENSOR_I, FORWARD_END_SENSOR_I};

	// Run style taken live from the command word, no start needed
	assign style = vel_mode_pkg::run_style_t'(s.cmd[vel_mode_pkg::CMD_STYLE_LSB +: 2]);
	assign halt      = s.cmd[vel_mode_pkg::CMD_HALT_BIT];
	assign limit_act = (|s.sync2[PIN_TORQUE-1:0]) | s.sw_limit;
	// Motion is blocked by halt, alarm, limit or drive not enabled
	assign stop_req  = halt | s.ovl_alarm | s.dev_alarm | limit_act
		| !DRIVE_STATE_I[vel_mode_pkg::DRV_OP_EN_BIT];
	assign target_eff = stop_req ? 32'sh0 : s.target;
	assign dev_mag    = DEVIATION_I[31] ? 32'(-DEVIATION_I) : DEVIATION_I;
	assign corr       = $signed(DEVIATION_I) >>> vel_mode_pkg::DEV_GAIN_SHIFT;
	assign wr_en      = PSEL_I & PENABLE_I & s.pready & PWRITE_I;
	assign frst_edge  = s.cmd[vel_mode_pkg::CMD_FRST_BIT] & !s.frst_d;

	// Ramp: jump in torque style, otherwise ramp from start speed
	speed_ramp #(
		.W(32)
	) u_ramp (
		.clk_i   (CLK_SYS_I),
		.rstn_i  (RSTN_I),
		.tick_i  (s.tick),
		.jump_i  (style == vel_mode_pkg::STYLE_TORQUE),
		.target_i(target_eff),
		.start_i (s.start),
		.step_i  (s.accel),
		.speed_o (ramp_speed)
	);

	// Read data mux and address decode
	always_comb begin
		rd_hit  = 1'b1;
		rd_data = '0;
		unique case (PADDR_I)
			vel_mode_pkg::ADDR_CMD:        rd_data = {16'h0000, s.cmd};
			vel_mode_pkg::ADDR_STATE:      rd_data = {16'h0000, s.status};
			vel_mode_pkg::ADDR_TARGET:     rd_data = s.target;
			vel_mode_pkg::ADDR_START:      rd_data = s.start;
			vel_mode_pkg::ADDR_ACCEL:      rd_data = s.accel;
			vel_mode_pkg::ADDR_DEV_LIMIT:  rd_data = s.dev_limit;
			vel_mode_pkg::ADDR_SPEED:      rd_data = ramp_speed;
			vel_mode_pkg::ADDR_LIMIT_CTRL: rd_data = {31'h0, s.sw_limit};
			vel_mode_pkg::ADDR_ALARM:      rd_data = {30'h0, s.dev_alarm, s.ovl_alarm};
			default:                       rd_hit = 1'b0;
		endcase
	end

	// Next state of the whole block
	always_comb begin
		next_s       = s;
		// Two-stage synchronisers for the pins
		next_s.sync1 = pins;
		next_s.sync2 = s.sync1;
		// Ramp tick divider
		next_s.tick  = 1'b0;
		if (s.tick_cnt == vel_mode_pkg::TICK_CNT_W'(vel_mode_pkg::RAMP_TICK_CYCLES - 1)) begin
			next_s.tick_cnt = '0;
			next_s.tick     = 1'b1;
		end else begin
			next_s.tick_cnt = s.tick_cnt + 1'b1;
		end
		// Initialisation timer
		if (!s.init_done) begin
			if (s.init_cnt == vel_mode_pkg::INIT_CNT_W'(vel_mode_pkg::INIT_CYCLES - 1)) begin
				next_s.init_done = 1'b1;
			end else begin
				next_s.init_cnt = s.init_cnt + 1'b1;
			end
		end
		// APB access: one wait state, answer in the second access cycle
		next_s.pready  = 1'b0;
		next_s.pslverr = 1'b0;
		if (PSEL_I && PENABLE_I && !s.pready) begin
			next_s.pready  = 1'b1;
			next_s.prdata  = rd_data;
			next_s.pslverr = !rd_hit;
		end
		if (wr_en) begin
			unique case (PADDR_I)
				vel_mode_pkg::ADDR_CMD:        next_s.cmd = PWDATA_I[15:0];
				vel_mode_pkg::ADDR_TARGET:     next_s.target = PWDATA_I;
				vel_mode_pkg::ADDR_START:      next_s.start = PWDATA_I;
				vel_mode_pkg::ADDR_ACCEL:      next_s.accel = PWDATA_I;
				vel_mode_pkg::ADDR_DEV_LIMIT:  next_s.dev_limit = PWDATA_I;
				vel_mode_pkg::ADDR_LIMIT_CTRL: next_s.sw_limit = PWDATA_I[0];
				default:                       next_s.frst_d = s.frst_d;
			endcase
		end
		next_s.frst_d = s.cmd[vel_mode_pkg::CMD_FRST_BIT];
		// Fault reset clears alarms; a new cause in the same cycle wins
		if (frst_edge) begin
			next_s.ovl_alarm = 1'b0;
			next_s.dev_alarm = 1'b0;
		end
		// Overload: torque ceiling held too long in styles 00 and 01
		if (s.sync2[PIN_TORQUE] && ramp_speed != '0
			&& (style == vel_mode_pkg::STYLE_POSITION || style == vel_mode_pkg::STYLE_SPEED)) begin
			if (s.ovl_cnt != vel_mode_pkg::OVL_CNT_W'(OVL_CYCLES - 1)) begin
				next_s.ovl_cnt = s.ovl_cnt + 1'b1;
			end else begin
				next_s.ovl_alarm = 1'b1;
			end
		end else begin
			next_s.ovl_cnt = '0;
		end
		// Deviation supervision only in position style
		if (style == vel_mode_pkg::STYLE_POSITION && dev_mag > s.dev_limit) begin
			next_s.dev_alarm = 1'b1;
		end
		// Pressing against the load in push and torque styles
		next_s.push_hold = style[1] & s.sync2[PIN_TORQUE];
		// Motor speed: ramp plus catch-up in position style
		if (s.ovl_alarm || s.dev_alarm) begin
			next_s.motor_speed = '0;
		end else if (style == vel_mode_pkg::STYLE_POSITION) begin
			next_s.motor_speed = ramp_speed + corr;
		end else begin
			next_s.motor_speed = ramp_speed;
		end
		// Status word
		next_s.status = {s.sync2[PIN_TORQUE], 2'b00, ramp_speed == '0, limit_act,
			halt ? ramp_speed == '0 : ramp_speed == s.target, s.init_done, 1'b0,
			WARNING_I, DRIVE_STATE_I};
	end

	// State register
	always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			s           <= '0;
			s.cmd       <= vel_mode_pkg::CMD_RST;
			s.target    <= vel_mode_pkg::TARGET_RST;
			s.start     <= vel_mode_pkg::START_RST;
			s.accel     <= vel_mode_pkg::ACCEL_RST;
			s.dev_limit <= vel_mode_pkg::DEV_LIMIT_RST;
		end else begin
			s <= next_s;
		end
	end

	// Outputs straight from flip-flops
	assign PRDATA_O           = s.prdata;
	assign PREADY_O           = s.pready;
	assign PSLVERR_O          = s.pslverr;
	assign MOTOR_SPEED_O      = s.motor_speed;
	assign DRIVE_STATE_WORD_O = s.status;
	assign ALARM_OVERLOAD_O   = s.ovl_alarm;
	assign ALARM_DEVIATION_O  = s.dev_alarm;
	assign PUSH_HOLD_O        = s.push_hold;

	// Checks on the style, ramp, alarm and status behaviour
	property p_torque_jump;
		@(posedge CLK_SYS_I) disable iff (!RSTN_I)
		(style == vel_mode_pkg::STYLE_TORQUE && !stop_req) |=> ramp_speed == $past(s.target);
	endproperty
	a_torque_jump: assert property (p_torque_jump) else $error("torque style did not jump");

	property p_start_speed;
		@(posedge CLK_SYS_I) disable iff (!RSTN_I)
		(s.tick && ramp_speed == '0 && style != vel_mode_pkg::STYLE_TORQUE
			&& target_eff > $signed(s.start) && s.start != '0)
		|=> ramp_speed == $signed($past(s.start));
	endproperty
	a_start_speed: assert property (p_start_speed) else $error("ramp not at start speed");

	property p_dev_alarm;
		@(posedge CLK_SYS_I) disable iff (!RSTN_I)
		(style == vel_mode_pkg::STYLE_POSITION && dev_mag > s.dev_limit) |=> s.dev_alarm;
	endproperty
	a_dev_alarm: assert property (p_dev_alarm) else $error("deviation alarm missing");

	property p_speed_no_dev;
		@(posedge CLK_SYS_I) disable iff (!RSTN_I)
		$rose(s.dev_alarm) |-> $past(style) == vel_mode_pkg::STYLE_POSITION;
	endproperty
	a_speed_no_dev: assert property (p_speed_no_dev) else $error("deviation alarm off style");

	property p_push_no_ovl;
		@(posedge CLK_SYS_I) disable iff (!RSTN_I)
		style[1] |=> !$rose(s.ovl_alarm);
	endproperty
	a_push_no_ovl: assert property (p_push_no_ovl) else $error("overload in push style");

	property p_torque_flag;
		@(posedge CLK_SYS_I) disable iff (!RSTN_I)
		1'b1 |=> s.status[vel_mode_pkg::ST_TORQUE_BIT] == $past(s.sync2[PIN_TORQUE]);
	endproperty
	a_torque_flag: assert property (p_torque_flag) else $error("torque flag wrong");

	property p_zero_flag;
		@(posedge CLK_SYS_I) disable iff (!RSTN_I)
		1'b1 |=> s.status[vel_mode_pkg::ST_ZERO_BIT] == ($past(ramp_speed) == '0);
	endproperty
	a_zero_flag: assert property (p_zero_flag) else $error("zero speed flag wrong");

	property p_limit_flag;
		@(posedge CLK_SYS_I) disable iff (!RSTN_I)
		(|s.sync2[PIN_TORQUE-1:0]) |=> s.status[vel_mode_pkg::ST_LIMIT_BIT];
	endproperty
	a_limit_flag: assert property (p_limit_flag) else $error("limit flag missing");

	property p_init;
		@(posedge CLK_SYS_I) disable iff (!RSTN_I)
		$rose(s.init_done) |-> $past(s.init_cnt)
			== vel_mode_pkg::INIT_CNT_W'(vel_mode_pkg::INIT_CYCLES - 1);
	endproperty
	a_init: assert property (p_init) else $error("init done at wrong time");

	property p_halt_reached;
		@(posedge CLK_SYS_I) disable iff (!RSTN_I)
		(halt && ramp_speed == '0) |=> s.status[vel_mode_pkg::ST_REACHED_BIT];
	endproperty
	a_halt_reached: assert property (p_halt_reached) else $error("halt reached flag missing");

	property p_halt_hold;
		@(posedge CLK_SYS_I) disable iff (!RSTN_I)
		(halt && ramp_speed == '0) ##1 halt |-> ramp_speed == '0;
	endproperty
	a_halt_hold: assert property (p_halt_hold) else $error("moved while halted");

	c_ovl: cover property (@(posedge CLK_SYS_I) disable iff (!RSTN_I) $rose(s.ovl_alarm));
	c_dev: cover property (@(posedge CLK_SYS_I) disable iff (!RSTN_I) $rose(s.dev_alarm));
	c_reach: cover property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
		!halt && ramp_speed != '0 && ramp_speed == s.target);
	c_push: cover property (@(posedge CLK_SYS_I) disable iff (!RSTN_I) $rose(s.push_hold));
endmodule : vel_mode_ctrl

//--- testbench/apb_master_model.sv
/*
 APB master model standing in for the fieldbus motion controller.
 Assumes one rising-edge clock shared with the slave it drives.
*/
`timescale 1ns/10ps
module apb_master_model (
	input  wire logic        clk_i,
	input  wire logic        pready_i,
	input  wire logic        pslverr_i,
	input  wire logic [31:0] prdata_i,
	output logic             psel_o,
	output logic             penable_o,
	output logic             pwrite_o,
	output logic      [15:0] paddr_o,
	output logic      [31:0] pwdata_o
);
	// Idle bus at time zero
	initial begin
		psel_o = 1'b0;
		penable_o = 1'b0;
		pwrite_o = 1'b0;
		paddr_o = 16'h0000;
		pwdata_o = 32'h0000_0000;
	end

	// One transfer held until pready; released lines show inverted data
	task automatic xfer(input logic wr, input logic [15:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err, output logic ok);
		int n;
		@(posedge clk_i);
		psel_o <= 1'b1;
		penable_o <= 1'b0;
		pwrite_o <= wr;
		paddr_o <= a;
		pwdata_o <= d;
		@(posedge clk_i);
		penable_o <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready_i !== 1'b1 && n < 64);
		ok = (pready_i === 1'b1);
		rd = prdata_i;
		err = pslverr_i;
		psel_o <= 1'b0;
		penable_o <= 1'b0;
		paddr_o <= ~a;
		pwdata_o <= ~d;
	endtask : xfer
endmodule : apb_master_model

//--- testbench/velocity_mode_run_style_status_bench.sv
/*
 Self-checking bench for the profile velocity block.
 Assumes the APB master model and a 100 MHz clock.
*/
`timescale 1ns/10ps
module velocity_mode_run_style_status_bench;
	logic               clk, rstn, psel, penable, pwrite, pready, pslverr;
	logic        [15:0] paddr, sw;
	logic        [31:0] pwdata, prdata, r;
	logic               fw, rv, fi, ri, tq, wn, ovl, dva, push, e, lim;
	logic signed [31:0] dev, speed, t;
	logic        [6:0]  ds;
	int                 n_mismatch, check_count;
	logic        [15:0] ra[5] = '{vel_mode_pkg::ADDR_CMD, vel_mode_pkg::ADDR_TARGET,
		vel_mode_pkg::ADDR_START, vel_mode_pkg::ADDR_ACCEL, vel_mode_pkg::ADDR_DEV_LIMIT};
	logic        [31:0] rv_exp[5] = '{{16'h0000, vel_mode_pkg::CMD_RST},
		vel_mode_pkg::TARGET_RST, vel_mode_pkg::START_RST, vel_mode_pkg::ACCEL_RST,
		vel_mode_pkg::DEV_LIMIT_RST};

	apb_master_model m (.clk_i(clk), .pready_i(pready), .pslverr_i(pslverr),
		.prdata_i(prdata), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
		.paddr_o(paddr), .pwdata_o(pwdata));

	vel_mode_ctrl #(.OVL_CYCLES(8)) dut (.CLK_SYS_I(clk), .RSTN_I(rstn), .PSEL_I(psel),
		.PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
		.PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
		.FORWARD_END_SENSOR_I(fw), .REVERSE_END_SENSOR_I(rv),
		.FORWARD_MOTION_INHIBIT_I(fi), .REVERSE_MOTION_INHIBIT_I(ri),
		.TORQUE_CEILING_HIT_I(tq), .DEVIATION_I(dev), .WARNING_I(wn),
		.DRIVE_STATE_I(ds), .MOTOR_SPEED_O(speed), .DRIVE_STATE_WORD_O(sw),
		.ALARM_OVERLOAD_O(ovl), .ALARM_DEVIATION_O(dva), .PUSH_HOLD_O(push));

	// Clock
	initial clk = 1'b0;
	always #5 clk = ~clk;

	// Verdict and end of run
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : wrap_up

	// Compare seen against expected
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// Bus access through the master model
	task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d);
		logic ok;
		m.xfer(w, a, d, r, e, ok);
		if (ok !== 1'b1) begin
			n_mismatch++;
			wrap_up();
		end
	endtask : acc

	// Bounded wait for speed to match (eq) or leave (!eq) a value
	task automatic wait_spd(input logic signed [31:0] v, input bit eq);
		int n;
		for (n = 0; n < 4000 && ((speed === v) != eq); n++) begin
			@(posedge clk);
		end
		if (n == 4000) begin
			n_mismatch++;
			$display("CHECK FAILED speed wait expected %h seen %h", v, speed);
			wrap_up();
		end
	endtask : wait_spd

	// Command word from style, halt and fault reset
	function automatic logic [31:0] cmdw(logic [1:0] s, logic h, logic f);
		return {16'h0000, 2'b00, s, 3'b000, h, f, 7'h00};
	endfunction : cmdw

	// Status word expected while speed and target are zero
	function automatic logic [15:0] idle_word(logic q, logic l, logic w, logic [6:0] d);
		return {q, 2'b00, 1'b1, l, 1'b1, 1'b1, 1'b0, w, d};
	endfunction : idle_word

	// Main sequence
	initial begin
		{rstn, fw, rv, fi, ri, tq, wn} <= '0;
		dev <= 32'sh0;
		ds <= 7'h00;
		void'($urandom(6060));
		repeat (8) @(posedge clk);
		chk("word in reset", sw, 32'h0);
		rstn <= 1'b1;
		repeat (150) @(posedge clk);
		chk("init early", sw[9], 1'b0);
		repeat (60) @(posedge clk);
		chk("init done", sw[9], 1'b1);
		foreach (ra[i]) begin
			acc(1'b0, ra[i], 32'h0);
			chk("reset value", r, rv_exp[i]);
		end
		acc(1'b0, 16'h6100, 32'h0);
		chk("unmapped err", e, 1'b1);
		chk("unmapped data", r, 32'h0);
		$display("test registers done");
		// Random pins, warning, drive state and software limit
		for (int i = 0; i < 8; i++) begin
			{fw, rv, fi, ri, tq, wn} <= 6'($urandom);
			ds <= 7'($urandom);
			lim = 1'($urandom);
			acc(1'b1, vel_mode_pkg::ADDR_LIMIT_CTRL, {31'h0, lim});
			acc(1'b1, vel_mode_pkg::ADDR_STATE, 32'hffff_ffff);
			repeat (5) @(posedge clk);
			lim = lim | fw | rv | fi | ri;
			chk("status pins", sw, idle_word(tq, lim, wn, ds));
			acc(1'b0, vel_mode_pkg::ADDR_STATE, 32'h0);
			chk("status read", r, {16'h0, idle_word(tq, lim, wn, ds)});
		end
		{fw, rv, fi, ri, tq, wn} <= '0;
		ds <= 7'h27;
		acc(1'b1, vel_mode_pkg::ADDR_LIMIT_CTRL, 32'h0);
		$display("test status done");
		// Ramp in speed style
		acc(1'b1, vel_mode_pkg::ADDR_ACCEL, 32'h0000_03e8);
		acc(1'b1, vel_mode_pkg::ADDR_CMD, cmdw(vel_mode_pkg::STYLE_SPEED, 1'b0, 1'b0));
		acc(1'b1, vel_mode_pkg::ADDR_TARGET, 32'h0000_4e20);
		wait_spd(32'sh0, 1'b0);
		chk("start speed", speed, 32'h0000_1388);
		wait_spd(32'sh0000_1388, 1'b0);
		chk("first step", speed, 32'h0000_1770);
		wait_spd(32'sh0000_4e20, 1'b1);
		repeat (300) @(posedge clk);
		chk("held speed", speed, 32'h0000_4e20);
		chk("reached", sw[10], 1'b1);
		chk("not zero", sw[12], 1'b0);
		// Halt, decelerate, resume
		acc(1'b1, vel_mode_pkg::ADDR_CMD, cmdw(vel_mode_pkg::STYLE_SPEED, 1'b1, 1'b0));
		wait_spd(32'sh0000_4a38, 1'b1);
		wait_spd(32'sh0, 1'b1);
		repeat (3) @(posedge clk);
		chk("halt zero", sw[12], 1'b1);
		chk("halt reached", sw[10], 1'b1);
		acc(1'b1, vel_mode_pkg::ADDR_CMD, cmdw(vel_mode_pkg::STYLE_SPEED, 1'b0, 1'b0));
		wait_spd(32'sh0, 1'b0);
		chk("resume", speed, 32'h0000_1388);
		// Style change mid-ramp steps straight to target
		acc(1'b1, vel_mode_pkg::ADDR_CMD, cmdw(vel_mode_pkg::STYLE_TORQUE, 1'b0, 1'b0));
		repeat (4) @(posedge clk);
		chk("torque step", speed, 32'h0000_4e20);
		for (int i = 0; i < 4; i++) begin
			t = $signed($urandom_range(32'h0000_ea60)) - 32'sh0000_7530;
			acc(1'b1, vel_mode_pkg::ADDR_TARGET, t);
			repeat (4) @(posedge clk);
			chk("torque target", speed, t);
			chk("torque reached", sw[10], 1'b1);
		end
		acc(1'b1, vel_mode_pkg::ADDR_TARGET, 32'h0000_4e20);
		$display("test ramp done");
		// Speed style: overload only, no deviation alarm
		acc(1'b1, vel_mode_pkg::ADDR_CMD, cmdw(vel_mode_pkg::STYLE_SPEED, 1'b0, 1'b0));
		dev <= 32'sh0000_1388;
		tq <= 1'b1;
		repeat (20) @(posedge clk);
		chk("overload", ovl, 1'b1);
		chk("no deviation", dva, 1'b0);
		chk("speed on alarm", speed, 32'h0);
		tq <= 1'b0;
		dev <= 32'sh0;
		acc(1'b1, vel_mode_pkg::ADDR_CMD, cmdw(vel_mode_pkg::STYLE_POSITION, 1'b0, 1'b1));
		acc(1'b1, vel_mode_pkg::ADDR_CMD, cmdw(vel_mode_pkg::STYLE_POSITION, 1'b0, 1'b0));
		repeat (3) @(posedge clk);
		chk("alarm cleared", ovl, 1'b0);
		// Position style: deviation catch-up and alarm
		dev <= 32'sh0000_0190;
		wait_spd(32'sh0000_4e84, 1'b1);
		chk("catch up", speed, 32'h0000_4e84);
		dev <= 32'sh0000_1388;
		repeat (6) @(posedge clk);
		chk("deviation alarm", dva, 1'b1);
		dev <= 32'sh0;
		acc(1'b1, vel_mode_pkg::ADDR_CMD, cmdw(vel_mode_pkg::STYLE_PUSH, 1'b0, 1'b1));
		acc(1'b1, vel_mode_pkg::ADDR_CMD, cmdw(vel_mode_pkg::STYLE_PUSH, 1'b0, 1'b0));
		$display("test alarms done");
		// Push style keeps pressing without fault
		tq <= 1'b1;
		repeat (20) @(posedge clk);
		chk("push hold", push, 1'b1);
		chk("push no alarm", ovl, 1'b0);
		tq <= 1'b0;
		$display("test push done");
		wrap_up();
	end
endmodule : velocity_mode_run_style_status_bench
